// >>> mtu_mem_model.sv
// Purpose: Table memory that answers the walker's descriptor fetches.
// Assumes: The bench preloads tbl; absent words read as fault descriptors.
// Notes:   Idle read data flips every cycle so a stale word never looks valid.
module mtu_mem_model (
   input  wire logic        clk_i,      // Clock
   input  wire logic        reset_i,    // Async reset, active high
   input  wire logic        req_i,      // Fetch request
   input  wire logic [31:0] addr_i,     // Fetch address
   input  wire logic [3:0]  delay_i,    // Cycles to wait before answering
   output logic             ack_o,      // Fetch answered
   output logic      [31:0] rdata_o     // Descriptor
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] tbl [logic [31:0]];
   logic [3:0]  cnt_q;
   function automatic logic [31:0] rd(input logic [31:0] a);
      return tbl.exists(a) ? tbl[a] : 32'h0000_0000;
   endfunction
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         ack_o <= 1'b0;
         rdata_o <= 32'h0000_0000;
         cnt_q <= 4'h0;
      end else if (req_i && !ack_o && cnt_q >= delay_i) begin
         ack_o <= 1'b1;
         rdata_o <= rd(addr_i);
         cnt_q <= 4'h0;
      end else begin
         ack_o <= 1'b0;
         rdata_o <= ~rdata_o;
         cnt_q <= (req_i && !ack_o) ? 4'(cnt_q + 4'h1) : 4'h0;
      end
   end
endmodule

// >>> mtu_pkg.sv
// Purpose: Shared constants for the translation unit: register numbers, fields, codes.
// Assumes: Coprocessor register number arrives as a 4-bit index with each transfer.
// Notes:   Only internal fault codes are produced; external aborts are left out.
//
// Summary of operation
// R01 - Translate virtual address and check permission
// R02 - Support 1MB sections, 4Kb and 64Kb pages
// R03 - Sub-page permissions: 1Kb small, 16Kb large
// R04 - Domain register holds sixteen 2-bit fields
// R05 - Sixty-four entry TLB feeds permission logic
// R06 - Hit: permitted drives address, else abort
// R07 - Miss starts walk, loads result into TLB
// R08 - Replacement steps round-robin through entries
// R09 - Disabled unit passes virtual address unchanged
// R10 - Registers reached only by coprocessor transfers
// R11 - Software aligns table base on 16KB
// R12 - Fault status bits 7:4 capture domain
// R13 - Status bits 3:1 type, bit 0 internal/external
// R14 - Any fault status write flushes whole TLB; a load in that same cycle keeps its new entry
// R15 - Fault address captures faulting virtual address
// R16 - Fault address write purges matching entry
// R17 - Only data faults update fault registers
// R18 - Walk: level one, pages add level two
// R19 - Software avoids reserved register numbers
// R20 - Level one address: base 31:14, VA 31:20
// R21 - Level one type: fault, table, section, reserved
// R22 - Level two type: fault, large, small, reserved
// R23 - Software sets control bit 0 to enable
// R24 - All entries invalid after reset
// R25 - Walked access rechecked like a TLB hit
package mtu_pkg;
   localparam logic [3:0] REG_CONTROL = 4'h1;
   localparam logic [3:0] REG_TBASE   = 4'h2;
   localparam logic [3:0] REG_DOMAIN  = 4'h3;
   localparam logic [3:0] REG_FSTAT   = 4'h5;
   localparam logic [3:0] REG_FADDR   = 4'h6;
   localparam int CTL_ENABLE = 0;
   localparam int CTL_SYS    = 8;
   localparam int CTL_ROM    = 9;
   localparam logic [1:0] DESC_FAULT = 2'h0;
   localparam logic [1:0] DESC_TABLE = 2'h1;
   localparam logic [1:0] DESC_SECT  = 2'h2;
   localparam logic [1:0] DESC_LARGE = 2'h1;
   localparam logic [1:0] DESC_SMALL = 2'h2;
   localparam logic [1:0] DOM_NONE    = 2'h0;
   localparam logic [1:0] DOM_CLIENT  = 2'h1;
   localparam logic [1:0] DOM_MANAGER = 2'h3;
   localparam logic [3:0] FS_SECT_TRANS = 4'h5;
   localparam logic [3:0] FS_PAGE_TRANS = 4'h7;
   localparam logic [3:0] FS_SECT_DOM   = 4'h9;
   localparam logic [3:0] FS_PAGE_DOM   = 4'hB;
   localparam logic [3:0] FS_SECT_PERM  = 4'hD;
   localparam logic [3:0] FS_PAGE_PERM  = 4'hF;
   localparam logic [31:0] FSTAT_RESET = 32'h0000_0000;
   localparam logic [31:0] FADDR_RESET = 32'h0000_0000;
   localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
   typedef enum logic [1:0] {MTU_SECT, MTU_LARGE, MTU_SMALL} mtu_size_t;
endpackage

// >>> mtu_tlb_unit.sv
// Purpose: Address translation unit with TLB, permission check and table walker.
// Assumes: Core holds a request until done_o or abort_o; memory answers with mem_ack_i.
// Notes:   One request at a time; register writes may arrive at any cycle.
module mtu_tlb_unit #(
   parameter int ENTRIES = 64                  // TLB depth
) (
   input  wire logic        clk_i,             // 125 MHz clock
   input  wire logic        reset_i,           // Async reset, active high
   input  wire logic        cp_wr_i,           // Coprocessor write pulse
   input  wire logic        cp_rd_i,           // Coprocessor read pulse
   input  wire logic [3:0]  cp_reg_i,          // Register number
   input  wire logic [31:0] cp_wdata_i,        // Write data
   output logic      [31:0] cp_rdata_o,        // Read data
   output logic             cp_rvalid_o,       // Read data valid pulse
   input  wire logic        req_i,             // Access request
   input  wire logic [31:0] vaddr_i,           // Virtual address
   input  wire logic        write_i,           // Access is a write
   input  wire logic        user_i,            // Access in user mode
   input  wire logic        data_i,            // Data access, not prefetch
   output logic      [31:0] paddr_o,           // Physical address
   output logic             done_o,            // Access permitted pulse
   output logic             abort_o,           // Access aborted pulse
   output logic             mem_req_o,         // Table fetch request
   output logic      [31:0] mem_addr_o,        // Table fetch address
   input  wire logic        mem_ack_i,         // Table fetch answered
   input  wire logic [31:0] mem_rdata_i        // Descriptor returned
);
   import mtu_pkg::*;

   localparam int IW = $clog2(ENTRIES);
   typedef enum {ST_IDLE, ST_LOOKUP, ST_WALK1, ST_WALK2, ST_ANSWER} mtu_state_t;

   mtu_state_t      st_q;
   logic [31:0]     ctrl_q, tbase_q, dom_q, fstat_q, faddr_q;
   logic [31:0]     va_q, l1_q;
   logic            wr_q, user_q, data_q;
   logic [ENTRIES-1:0] valid_q;
   logic [19:0]     tag_q  [ENTRIES];
   logic [19:0]     ppn_q  [ENTRIES];
   mtu_size_t       size_q [ENTRIES];
   logic [3:0]      edom_q [ENTRIES];
   logic [7:0]      ap_q   [ENTRIES];
   logic [IW-1:0]   rr_q;

   // Tag compare width follows the mapping size of each entry
   function automatic logic tag_hit(input logic [19:0] tag, input mtu_size_t sz,
                                    input logic [31:0] va);
      unique case (sz)
         MTU_SECT:  tag_hit = tag[19:8] == va[31:20];
         MTU_LARGE: tag_hit = tag[19:4] == va[31:16];
         default:   tag_hit = tag == va[31:12]; // Small page
      endcase
   endfunction

   // AP decode with the S and R control bits
   function automatic logic ap_ok(input logic [1:0] ap, input logic s, input logic r,
                                  input logic wr, input logic usr);
      unique case (ap)
         2'h0:    ap_ok = !wr && ((s && !r && !usr) || (!s && r));
         2'h1:    ap_ok = !usr;
         2'h2:    ap_ok = !usr || !wr;
         2'h3:    ap_ok = 1'b1;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // TLB search and permission check

   logic            hit;
   logic [IW-1:0]   hit_idx;
   logic [31:0]     pa;
   logic [1:0]      sub_ap, dright;
   logic            perm_ok, is_sect;
   logic [3:0]      hdom, perm_code;

   always_comb begin
      hit     = 1'b0;
      hit_idx = '0;
      for (int i = 0; i < ENTRIES; i++) begin
         if (valid_q[i] && tag_hit(tag_q[i], size_q[i], va_q)) begin // R05
            hit     = 1'b1;
            hit_idx = IW'(i);
         end
      end
   end

   always_comb begin
      hdom    = edom_q[hit_idx];
      is_sect = size_q[hit_idx] == MTU_SECT;
      unique case (size_q[hit_idx]) // R02 R03
         MTU_SECT: begin
            pa     = {ppn_q[hit_idx][19:8], va_q[19:0]};
            sub_ap = ap_q[hit_idx][1:0];
         end
         MTU_LARGE: begin
            pa     = {ppn_q[hit_idx][19:4], va_q[15:0]};
            sub_ap = ap_q[hit_idx][2*va_q[15:14] +: 2];
         end
         default: begin // Small page; an unloaded slot lands here too
            pa     = {ppn_q[hit_idx], va_q[11:0]};
            sub_ap = ap_q[hit_idx][2*va_q[11:10] +: 2];
         end
      endcase
      dright    = dom_q[2*hdom +: 2]; // R04
      perm_code = is_sect ? FS_SECT_DOM : FS_PAGE_DOM;
      perm_ok   = 1'b0;
      if (dright == DOM_MANAGER) begin
         perm_ok = 1'b1;
      end else if (dright == DOM_CLIENT) begin
         perm_ok   = ap_ok(sub_ap, ctrl_q[CTL_SYS], ctrl_q[CTL_ROM], wr_q, user_q);
         perm_code = is_sect ? FS_SECT_PERM : FS_PAGE_PERM;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Walker state machine and access answer

   logic        fault_set;
   logic [7:0]  fault_val;
   logic        load_en;
   logic [19:0] load_tag, load_ppn;
   mtu_size_t   load_size;
   logic [7:0]  load_ap;

   always_comb begin
      fault_set = 1'b0;
      fault_val = {hdom, perm_code};
      load_en   = 1'b0;
      load_tag  = va_q[31:12];
      load_ppn  = mem_rdata_i[31:12];
      load_size = MTU_SECT;
      load_ap   = {6'h00, mem_rdata_i[11:10]};
      if (st_q == ST_LOOKUP && ctrl_q[CTL_ENABLE] && hit && !perm_ok) begin
         fault_set = 1'b1; // R06
      end
      if (st_q == ST_WALK1 && mem_ack_i) begin
         if (mem_rdata_i[1:0] == DESC_SECT) begin
            load_en = 1'b1; // R18
         end else if (mem_rdata_i[1:0] != DESC_TABLE) begin
            fault_set = 1'b1; // R21
            fault_val = {mem_rdata_i[8:5], FS_SECT_TRANS};
         end
      end
      if (st_q == ST_WALK2 && mem_ack_i) begin
         load_ap = mem_rdata_i[11:4];
         if (mem_rdata_i[1:0] == DESC_LARGE) begin
            load_en   = 1'b1; // R22
            load_size = MTU_LARGE;
         end else if (mem_rdata_i[1:0] == DESC_SMALL) begin
            load_en   = 1'b1;
            load_size = MTU_SMALL;
         end else begin
            fault_set = 1'b1;
            fault_val = {l1_q[8:5], FS_PAGE_TRANS};
         end
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         st_q       <= ST_IDLE;
         va_q       <= '0;
         l1_q       <= '0;
         wr_q       <= 1'b0;
         user_q     <= 1'b0;
         data_q     <= 1'b0;
         paddr_o    <= '0;
         done_o     <= 1'b0;
         abort_o    <= 1'b0;
         mem_req_o  <= 1'b0;
         mem_addr_o <= '0;
      end else begin
         done_o  <= 1'b0;
         abort_o <= 1'b0;
         unique case (st_q)
            ST_IDLE: begin
               if (req_i) begin
                  va_q   <= vaddr_i;
                  wr_q   <= write_i;
                  user_q <= user_i;
                  data_q <= data_i;
                  st_q   <= ST_LOOKUP;
               end
            end
            ST_LOOKUP: begin
               if (!ctrl_q[CTL_ENABLE]) begin
                  paddr_o <= va_q; // R09
                  done_o  <= 1'b1;
                  st_q    <= ST_ANSWER;
               end else if (hit) begin
                  paddr_o <= perm_ok ? pa : paddr_o; // R01 R06 R25
                  done_o  <= perm_ok;
                  abort_o <= !perm_ok;
                  st_q    <= ST_ANSWER;
               end else begin
                  mem_req_o  <= 1'b1; // R07
                  mem_addr_o <= {tbase_q[31:14], va_q[31:20], 2'b00}; // R20
                  st_q       <= ST_WALK1;
               end
            end
            ST_WALK1: begin
               if (mem_ack_i) begin
                  l1_q <= mem_rdata_i;
                  if (mem_rdata_i[1:0] == DESC_TABLE) begin
                     mem_addr_o <= {mem_rdata_i[31:10], va_q[19:12], 2'b00}; // R18
                  end else begin
                     mem_req_o <= 1'b0;
                  end
                  if (mem_rdata_i[1:0] == DESC_TABLE) begin
                     st_q <= ST_WALK2;
                  end else if (load_en) begin
                     st_q <= ST_LOOKUP; // R25
                  end else begin
                     abort_o <= 1'b1;
                     st_q    <= ST_ANSWER;
                  end
               end
            end
            ST_WALK2: begin
               if (mem_ack_i) begin
                  mem_req_o <= 1'b0;
                  abort_o   <= !load_en;
                  st_q      <= load_en ? ST_LOOKUP : ST_ANSWER;
               end
            end
            ST_ANSWER: begin
               // One idle cycle lets the core drop its request
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // TLB storage, replacement, flush and purge

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         valid_q <= '0; // R24
         rr_q    <= '0;
      end else begin
         for (int i = 0; i < ENTRIES; i++) begin
            if (cp_wr_i && cp_reg_i == REG_FSTAT) begin
               valid_q[i] <= 1'b0; // R14
            end else if (cp_wr_i && cp_reg_i == REG_FADDR &&
                         valid_q[i] && tag_hit(tag_q[i], size_q[i], cp_wdata_i)) begin
               valid_q[i] <= 1'b0; // R16
            end
         end
         // A load in the same cycle as a flush keeps its new entry
         if (load_en) begin
            valid_q[rr_q] <= 1'b1;
            rr_q          <= rr_q + 1'b1; // R08
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (load_en) begin
         tag_q[rr_q]  <= load_tag;
         ppn_q[rr_q]  <= load_ppn;
         size_q[rr_q] <= load_size;
         edom_q[rr_q] <= (load_size == MTU_SECT) ? mem_rdata_i[8:5] : l1_q[8:5];
         ap_q[rr_q]   <= load_ap;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Coprocessor registers

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         ctrl_q  <= CTRL_RESET;
         tbase_q <= '0;
         dom_q   <= '0;
      end else if (cp_wr_i) begin
         if (cp_reg_i == REG_CONTROL) ctrl_q <= cp_wdata_i;
         if (cp_reg_i == REG_TBASE) tbase_q <= {cp_wdata_i[31:14], 14'h0000};
         if (cp_reg_i == REG_DOMAIN) dom_q <= cp_wdata_i;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         fstat_q <= FSTAT_RESET;
         faddr_q <= FADDR_RESET;
      end else if (fault_set && data_q) begin // R17
         fstat_q <= {24'h00_0000, fault_val}; // R12 R13
         faddr_q <= va_q; // R15
      end
   end

   // Reserved register numbers read as zero and ignore writes
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         cp_rdata_o  <= '0;
         cp_rvalid_o <= 1'b0;
      end else begin
         cp_rvalid_o <= cp_rd_i;
         cp_rdata_o  <= (cp_reg_i == REG_FSTAT) ? fstat_q :
                        (cp_reg_i == REG_FADDR) ? faddr_q : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions

   disabled_pass_a: assert property (@(posedge clk_i) disable iff (reset_i) // R09
      st_q == ST_LOOKUP && !ctrl_q[CTL_ENABLE] |=> done_o && paddr_o == $past(va_q))
      else $error("disabled unit did not pass address");
   answer_excl_a: assert property (@(posedge clk_i) disable iff (reset_i) // R06
      !(done_o && abort_o))
      else $error("done and abort together");
   hit_abort_a: assert property (@(posedge clk_i) disable iff (reset_i) // R06
      st_q == ST_LOOKUP && ctrl_q[CTL_ENABLE] && hit && !perm_ok |=> abort_o && !done_o)
      else $error("refused hit did not abort");
   flush_all_a: assert property (@(posedge clk_i) disable iff (reset_i) // R14
      cp_wr_i && cp_reg_i == REG_FSTAT && !load_en |=> valid_q == '0)
      else $error("flush left valid entries");
   rr_step_a: assert property (@(posedge clk_i) disable iff (reset_i) // R08
      load_en |=> rr_q == IW'($past(rr_q) + 1'b1))
      else $error("replacement pointer did not step");
   prefetch_keep_a: assert property (@(posedge clk_i) disable iff (reset_i) // R17
      fault_set && !data_q |=> $stable(fstat_q) && $stable(faddr_q))
      else $error("prefetch fault changed fault registers");
   fault_record_a: assert property (@(posedge clk_i) disable iff (reset_i) // R12
      fault_set && data_q |=> fstat_q[7:0] == $past(fault_val) && faddr_q == $past(va_q))
      else $error("fault not recorded");
   l1_addr_a: assert property (@(posedge clk_i) disable iff (reset_i) // R20
      st_q == ST_WALK1 |-> mem_req_o && mem_addr_o == {tbase_q[31:14], va_q[31:20], 2'b00})
      else $error("wrong first level address");
   walk_start_a: assert property (@(posedge clk_i) disable iff (reset_i) // R07
      st_q == ST_LOOKUP && ctrl_q[CTL_ENABLE] && !hit |=> st_q == ST_WALK1 && mem_req_o)
      else $error("miss did not start walk");
endmodule

// >>> mtu_tlb_unit_tb.sv
// Purpose: Self-checking bench for the translation unit against a queue-free integer model.
// Assumes: Replacement pointer starts at entry 0 and steps once per loaded translation.
// Notes:   Depth is cut to 4 so eviction order shows within a few accesses.
module mtu_tlb_unit_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import mtu_pkg::*;
   localparam int ENT = 4;
   localparam logic [31:0] TB = 32'h0004_0000;
   localparam logic [31:0] PT = 32'h0080_0000;
   localparam logic [34:0] SC [14] = '{
      {32'h0012_3456, 3'h1}, {32'h001F_FFFC, 3'h7}, {32'h0020_0040, 3'h7},
      {32'h0020_0044, 3'h0}, {32'h0020_0048, 3'h6}, {32'h0030_0123, 3'h3},
      {32'h0030_0523, 3'h3}, {32'h0031_0000, 3'h7}, {32'h0031_F004, 3'h3},
      {32'h0032_0000, 3'h1}, {32'h0040_0000, 3'h1}, {32'h0050_0000, 3'h7},
      {32'h0060_0010, 3'h5}, {32'h0070_0000, 3'h1}};
   logic            clk_i = 0, reset_i = 1, cp_wr_i = 0, cp_rd_i = 0;
   logic            req_i = 0, write_i = 0, user_i = 0, data_i = 0;
   logic [3:0]      cp_reg_i = 4'h0, dly = 4'h0;
   logic [31:0]     cp_wdata_i = 0, vaddr_i = 0, cp_rdata_o, paddr_o, mem_addr_o, mem_rdata_i;
   logic            cp_rvalid_o, done_o, abort_o, mem_req_o, mem_ack_i;
   int              fail_count = 0, checks_done = 0, fetches = 0, rr = 0;
   int              seed = 32'h637A3242;
   logic [31:0]     tbase = 0, dacr = 0, fault_cause_and_tlb_flush = 0, fault_vaddr_and_entry_purge = 0, tag [ENT], msk [ENT];
   logic            en = 0;
   logic [ENT-1:0]  val = '0;

   always #4 clk_i = ~clk_i;
   always @(posedge clk_i) if (mem_req_o && mem_ack_i) fetches++;

   mtu_tlb_unit #(.ENTRIES(ENT)) uut (.clk_i(clk_i), .reset_i(reset_i), .cp_wr_i(cp_wr_i),
      .cp_rd_i(cp_rd_i), .cp_reg_i(cp_reg_i), .cp_wdata_i(cp_wdata_i), .cp_rdata_o(cp_rdata_o),
      .cp_rvalid_o(cp_rvalid_o), .req_i(req_i), .vaddr_i(vaddr_i), .write_i(write_i),
      .user_i(user_i), .data_i(data_i), .paddr_o(paddr_o), .done_o(done_o), .abort_o(abort_o),
      .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i),
      .mem_rdata_i(mem_rdata_i));
   mtu_mem_model mm (.clk_i(clk_i), .reset_i(reset_i), .req_i(mem_req_o), .addr_i(mem_addr_o),
      .delay_i(dly), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(string what, logic [31:0] e, logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", what, e, g);
         fail_count++;
      end
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic cp_write(logic [3:0] r, logic [31:0] d);
      @(posedge clk_i);
      cp_wr_i <= 1'b1;
      cp_reg_i <= r;
      cp_wdata_i <= d;
      @(posedge clk_i);
      cp_wr_i <= 1'b0;
      if (r == REG_CONTROL) en = d[CTL_ENABLE];
      if (r == REG_TBASE) tbase = d & 32'hFFFF_C000;
      if (r == REG_DOMAIN) dacr = d;
      if (r == REG_FSTAT) val = '0;
      for (int i = 0; i < ENT; i++) if (r == REG_FADDR && ((d ^ tag[i]) & msk[i]) == 0) val[i] = 0;
   endtask
   task automatic cp_read(logic [3:0] r, logic [31:0] e);
      @(posedge clk_i);
      cp_rd_i <= 1'b1;
      cp_reg_i <= r;
      @(posedge clk_i);
      cp_rd_i <= 1'b0;
      #1;
      check("read valid", 1, cp_rvalid_o);
      check("read data", e, cp_rdata_o);
   endtask
   // Translation rebuilt from the tables every time; the TLB copy only decides walk cost
   task automatic predict(input logic [31:0] va, input logic wr, usr, output logic ok,
                          output logic [31:0] pa, output int walks, output logic [7:0] fs);
      logic [31:0] d1, d2, m;
      logic [1:0]  ap, r;
      logic        pg;
      int          hit;
      ok = 1;
      pa = va;
      walks = 0;
      fs = 0;
      if (!en) return;
      d1 = mm.rd({tbase[31:14], va[31:20], 2'b00});
      pg = d1[1:0] == DESC_TABLE;
      walks = 1;
      fs = {d1[8:5], pg ? FS_PAGE_TRANS : FS_SECT_TRANS};
      ok = 0;
      m = 0;
      ap = 0;
      if (d1[1:0] == DESC_SECT) begin
         m = 32'hFFF0_0000;
         pa = {d1[31:20], va[19:0]};
         ap = d1[11:10];
      end
      if (pg) begin
         d2 = mm.rd({d1[31:10], va[19:12], 2'b00});
         walks = 2;
         if (d2[1:0] == DESC_LARGE) begin
            m = 32'hFFFF_0000;
            pa = {d2[31:16], va[15:0]};
            ap = d2[4 + 2 * va[15:14] +: 2];
         end
         if (d2[1:0] == DESC_SMALL) begin
            m = 32'hFFFF_F000;
            pa = {d2[31:12], va[11:0]};
            ap = d2[4 + 2 * va[11:10] +: 2];
         end
      end
      if (m != 0) begin
         hit = -1;
         for (int i = 0; i < ENT; i++) if (val[i] && ((va ^ tag[i]) & msk[i]) == 0) hit = i;
         if (hit >= 0) walks = 0;
         else begin
            tag[rr] = va;
            msk[rr] = m;
            val[rr] = 1;
            rr = (rr + 1) % ENT;
         end
         r = dacr[2 * d1[8:5] +: 2];
         fs[3:0] = pg ? FS_PAGE_DOM : FS_SECT_DOM;
         if (r == DOM_MANAGER) ok = 1;
         if (r == DOM_CLIENT) begin
            ok = ap == 2'h3 || (ap == 2'h2 && !(usr && wr)) || (ap == 2'h1 && !usr);
            fs[3:0] = pg ? FS_PAGE_PERM : FS_SECT_PERM;
         end
      end
   endtask
   task automatic access(logic [31:0] va, logic wr, usr, dat);
      logic        ok;
      logic [31:0] pa;
      logic [7:0]  fs;
      int          w, f0, n;
      predict(va, wr, usr, ok, pa, w, fs);
      if (!ok && dat) begin
         fault_cause_and_tlb_flush = {24'h0, fs};
         fault_vaddr_and_entry_purge = va;
      end
      f0 = fetches;
      @(posedge clk_i);
      dly <= 4'($random(seed)) & 4'h7;
      req_i <= 1'b1;
      vaddr_i <= va;
      write_i <= wr;
      user_i <= usr;
      data_i <= dat;
      n = 0;
      do begin
         @(posedge clk_i);
         #1;
         n++;
      end while (done_o !== 1'b1 && abort_o !== 1'b1 && n < 300);
      check("done", ok, done_o);
      check("abort", !ok, abort_o);
      if (ok) check("paddr", pa, paddr_o);
      check("fetch count", w, fetches - f0);
      @(posedge clk_i);
      req_i <= 1'b0;
      if (!ok) cp_read(REG_FSTAT, fault_cause_and_tlb_flush);
      if (!ok) cp_read(REG_FADDR, fault_vaddr_and_entry_purge);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk_i);
      $display("ERROR watchdog expected finish seen hang");
      fail_count++;
      stop_test;
   end
   initial begin
      mm.tbl[TB | 32'h4] = {12'h801, 8'h00, 2'h3, 1'b0, 4'h1, 5'h12};
      mm.tbl[TB | 32'h8] = {12'h802, 8'h00, 2'h1, 1'b0, 4'h1, 5'h12};
      mm.tbl[TB | 32'hC] = {22'h002000, 1'b0, 4'h2, 5'h11};
      mm.tbl[TB | 32'h10] = {12'h804, 8'h00, 2'h3, 1'b0, 4'h3, 5'h12};
      mm.tbl[TB | 32'h14] = {12'h805, 8'h00, 2'h0, 1'b0, 4'h4, 5'h12};
      mm.tbl[TB | 32'h1C] = 32'h0000_01F3;
      for (int i = 0; i < 5; i++) mm.tbl[TB | (32'h40 + 4 * i)] = {12'h810 + 12'(i), 20'h00C32};
      mm.tbl[PT] = {20'h00A00, 8'hF7, 4'h2};
      for (int i = 0; i < 16; i++) mm.tbl[PT | (32'h40 + 4 * i)] = {16'h00B0, 4'h0, 8'hFF, 4'h1};
      repeat (5) @(posedge clk_i);
      reset_i <= 1'b0;
      cp_read(REG_FSTAT, 32'h0000_0000);
      cp_read(REG_FADDR, 32'h0000_0000);
      repeat (4) access($random(seed), 1'($random(seed)), 1'($random(seed)), 1'b1);
      cp_write(REG_TBASE, TB);
      cp_write(REG_DOMAIN, 32'h5555_5715);
      cp_write(REG_CONTROL, 32'h0000_0001);
      for (int i = 0; i < 14; i++) access(SC[i][34:3], SC[i][2], SC[i][1], SC[i][0]);
      repeat (40) access({12'h001 + 12'({$random(seed)} % 7), 20'($random(seed))},
                         1'($random(seed)), 1'($random(seed)), 1'($random(seed)));
      cp_write(REG_FSTAT, $random(seed));
      access(32'h0010_0000, 1'b0, 1'b0, 1'b1);
      access(32'h0050_0000, 1'b0, 1'b0, 1'b1);
      cp_write(REG_FADDR, 32'h0015_5555);
      access(32'h0010_0004, 1'b0, 1'b0, 1'b1);
      access(32'h0050_0004, 1'b0, 1'b0, 1'b1);
      cp_write(REG_FSTAT, 32'h0000_0000);
      for (int i = 0; i < 5; i++) access(32'h0100_0000 + (i << 20), 1'b1, 1'b1, 1'b1);
      access(32'h0110_0000, 1'b0, 1'b1, 1'b1);
      access(32'h0100_0000, 1'b0, 1'b1, 1'b1);
      stop_test;
   end
endmodule
